/* rtl/xbus_pkg.sv */
// Constants for the stretchable external data bus engine
package xbus_pkg;
  // ----------------------------------------------------------------
  // Clock relations
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS  = 100;
  localparam int OSC_PERIOD_NS  = 200;   // oscillator_period
  localparam int TICKS_PER_OSC  = OSC_PERIOD_NS / SYS_PERIOD_NS;
  localparam int HALF_TICKS_INT = (TICKS_PER_OSC / 2 < 1) ? 1 : TICKS_PER_OSC / 2;
  localparam logic [7:0] HALF_TICKS = HALF_TICKS_INT[7:0];

  // ----------------------------------------------------------------
  // Stretch selection
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_RESET      = 3'h1;
  localparam int         SEL_W          = 3;
  localparam int         OSC_PER_MCYC   = 4;
  localparam int         BASE_MCYC      = 2;
  localparam int         STEP_OSC       = 4;   // stretch_interval growth per code
  localparam logic [7:0] MCYC_TICKS     = 8'(OSC_PER_MCYC * TICKS_PER_OSC);
  localparam logic [7:0] STEP_TICKS     = 8'(STEP_OSC * TICKS_PER_OSC);
  localparam logic [7:0] BASE_MCYC_B    = 8'(BASE_MCYC);

  // ----------------------------------------------------------------
  // Event positions, in half oscillator periods from access start
  // ----------------------------------------------------------------
  localparam logic [7:0] P2_AT_H        = 8'h01;
  localparam logic [7:0] P0_AT_H        = 8'h02;
  localparam logic [7:0] ALE_FALL_FAST  = 8'h03;
  localparam logic [7:0] ALE_FALL_SLOW  = 8'h04;
  localparam logic [7:0] STROBE_FAST    = 8'h04;
  localparam logic [7:0] STROBE_SLOW    = 8'h06;
  localparam logic [7:0] WIDTH_FAST     = 8'h04;
  localparam logic [7:0] HOLD_FAST      = 8'h02;
  localparam logic [7:0] HOLD_SLOW      = 8'h04;
  localparam logic [7:0] RELEASE_LEAD   = 8'h01;

  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_ACCESS = 1'b1
  } bus_state_t;
endpackage

/* rtl/pin_sync.sv */
// Two-stage synchroniser for a byte of pin inputs
`timescale 1ns/10ps
module pin_sync (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [7:0] din,
  output logic      [7:0] dout
);
  logic [7:0] stage1;

  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= 8'h00;
      dout   <= 8'h00;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // pin_sync

/* rtl/stretch_decode.sv */
// Stretch code to access event positions, in clock ticks
`timescale 1ns/10ps
module stretch_decode (
  input  wire logic [2:0] code,
  output logic            stretched,
  output logic      [7:0] ale_fall,
  output logic      [7:0] strobe_on,
  output logic      [7:0] strobe_off,
  output logic      [7:0] release_at,
  output logic      [7:0] drive_off,
  output logic      [7:0] last
);
  wire [7:0] code_b   = {5'h00, code};
  // Interval grows one step per code; code seven extrapolates to 28 clocks
  wire [7:0] interval = 8'(code_b * xbus_pkg::STEP_TICKS);  // see (R03) (R17)
  wire [7:0] width    = stretched ? interval : 8'(xbus_pkg::WIDTH_FAST * xbus_pkg::HALF_TICKS);

  assign stretched  = (code != 3'h0);
  assign ale_fall   = 8'((stretched ? xbus_pkg::ALE_FALL_SLOW : xbus_pkg::ALE_FALL_FAST) * xbus_pkg::HALF_TICKS);
  assign strobe_on  = 8'((stretched ? xbus_pkg::STROBE_SLOW : xbus_pkg::STROBE_FAST) * xbus_pkg::HALF_TICKS);
  assign strobe_off = 8'(strobe_on + width);
  assign release_at = 8'(strobe_on - 8'(xbus_pkg::RELEASE_LEAD * xbus_pkg::HALF_TICKS));
  assign drive_off  = 8'(strobe_off + 8'((stretched ? xbus_pkg::HOLD_SLOW : xbus_pkg::HOLD_FAST)
                                         * xbus_pkg::HALF_TICKS));
  assign last       = 8'(8'(code_b + xbus_pkg::BASE_MCYC_B) * xbus_pkg::MCYC_TICKS - 8'h01);
endmodule // stretch_decode

/* rtl/xbus_stretch.sv */
// External data move engine with selectable stretch length
// Contract
// (R01) Code sets access length, 2 to 9 cycles
// (R02) Reset selects code one, three cycles
// (R03) Stretch interval is four clocks per code
// (R04) Latch strobe high 1.5 or 2 clocks
// (R05) Write address held 0.5 or 1 clock
// (R06) Strobe follows latch fall 0.5 or 1
// (R07) Low address leads strobe 1 or 2
// (R08) High address leads strobe 1.5 or 2.5
// (R09) Port released half clock before read
// (R10) Partner returns data within strobe window
// (R11) Partner data valid after latch fall bound
// (R12) Partner holds data until strobe rises
// (R13) Partner floats data within 1 or 2
// (R14) Write data held 1 or 2 clocks
// (R15) Latch strobe rises after strobe ends
// (R16) Strobe width 2 clocks or interval
// (R17) Code seven gives twenty-eight clock interval
`timescale 1ns/10ps
module xbus_stretch (
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  input  wire logic        SEL_LOAD,
  input  wire logic [2:0]  SEL_DATA,
  output logic      [2:0]  SEL_CODE,
  input  wire logic        REQ_VALID,
  input  wire logic        REQ_WRITE,
  input  wire logic [15:0] REQ_ADDR,
  input  wire logic [7:0]  REQ_WDATA,
  output logic             REQ_READY,
  output logic             RSP_VALID,
  output logic      [7:0]  RSP_RDATA,
  output logic             ALE,
  output logic             RD_N,
  output logic             WR_N,
  output logic      [7:0]  P2_OUT,
  output logic      [7:0]  P0_OUT,
  output logic             P0_OE_N,
  input  wire logic [7:0]  P0_IN
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  xbus_pkg::bus_state_t state;
  xbus_pkg::bus_state_t next_state;
  logic [7:0]  cnt;
  logic [2:0]  acc_code;
  logic        acc_write;
  logic [15:0] acc_addr;
  logic [7:0]  acc_wdata;
  logic [7:0]  p0_sync;

  wire        stretched;
  wire [7:0]  ale_fall;
  wire [7:0]  strobe_on;
  wire [7:0]  strobe_off;
  wire [7:0]  release_at;
  wire [7:0]  drive_off;
  wire [7:0]  last;

  stretch_decode u_decode (
    .code       (acc_code),
    .stretched  (stretched),
    .ale_fall   (ale_fall),
    .strobe_on  (strobe_on),
    .strobe_off (strobe_off),
    .release_at (release_at),
    .drive_off  (drive_off),
    .last       (last)
  );

  pin_sync u_sync (
    .clk  (SYS_CLK),
    .rst  (RST),
    .din  (P0_IN),
    .dout (p0_sync)
  );

  // ----------------------------------------------------------------
  // Decoding of the access timeline
  // ----------------------------------------------------------------
  wire active       = (state == xbus_pkg::ST_ACCESS);
  // Ready gates the take so the first edge after reset refuses a request
  wire accept       = (state == xbus_pkg::ST_IDLE) && REQ_VALID && REQ_READY;
  wire done         = active && (cnt == last);
  wire in_strobe    = active && (cnt >= strobe_on) && (cnt < strobe_off);
  wire next_ale     = active && (cnt < ale_fall);                       // see (R04)
  wire next_rd_n    = !(in_strobe && !acc_write);                       // see (R16)
  wire next_wr_n    = !(in_strobe && acc_write);                        // see (R16)
  // Read frees the port one half clock ahead of the strobe
  wire rd_drive     = (cnt >= xbus_pkg::P0_AT_H) && (cnt < release_at);  // see (R09)
  wire wr_drive     = (cnt >= xbus_pkg::P0_AT_H) && (cnt < drive_off);   // see (R14)
  wire next_p0_en   = active && (acc_write ? wr_drive : rd_drive);      // see (R07)
  // Address stays until the strobe edge, then write data takes the port
  wire next_p0_data = acc_write && (cnt >= strobe_on);                  // see (R05)
  wire [7:0] next_p0 = next_p0_data ? acc_wdata : acc_addr[7:0];
  wire next_p2_ld   = active && (cnt == xbus_pkg::P2_AT_H);             // see (R08)
  // Two ticks of synchroniser lag: this is the pin value at the strobe's rising edge
  wire capture      = active && !acc_write && (cnt == 8'(strobe_off + 8'h02)); // see (R12)

  always_comb begin
    next_state = state;
    case (state)
      xbus_pkg::ST_IDLE: begin
        if (accept) begin
          next_state = xbus_pkg::ST_ACCESS;
        end
      end
      xbus_pkg::ST_ACCESS: begin
        if (done) begin
          next_state = xbus_pkg::ST_IDLE;                               // see (R01)
        end
      end
      default: begin
        next_state = xbus_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      SEL_CODE <= xbus_pkg::SEL_RESET;                                  // see (R02)
    end else if (SEL_LOAD) begin
      SEL_CODE <= SEL_DATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      state <= xbus_pkg::ST_IDLE;
      cnt   <= 8'h00;
    end else begin
      state <= next_state;
      cnt   <= active ? 8'(cnt + 8'h01) : 8'h00;
    end
  end

  // Setting is sampled per access so a mid-access change cannot tear it
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      acc_code  <= xbus_pkg::SEL_RESET;
      acc_write <= 1'b0;
      acc_addr  <= 16'h0000;
      acc_wdata <= 8'h00;
    end else if (accept) begin
      acc_code  <= SEL_CODE;                                            // see (R03)
      acc_write <= REQ_WRITE;
      acc_addr  <= REQ_ADDR;
      acc_wdata <= REQ_WDATA;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      ALE     <= 1'b0;
      RD_N    <= 1'b1;
      WR_N    <= 1'b1;
      P0_OE_N <= 1'b1;
      P0_OUT  <= 8'h00;
    end else begin
      ALE     <= next_ale;                                              // see (R15)
      RD_N    <= next_rd_n;                                             // see (R06)
      WR_N    <= next_wr_n;
      P0_OE_N <= !next_p0_en;
      P0_OUT  <= next_p0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      P2_OUT <= 8'h00;
    end else if (next_p2_ld) begin
      P2_OUT <= acc_addr[15:8];
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      REQ_READY <= 1'b0;
      RSP_VALID <= 1'b0;
      RSP_RDATA <= 8'h00;
    end else begin
      REQ_READY <= (next_state == xbus_pkg::ST_IDLE);
      RSP_VALID <= capture;
      if (capture) begin
        RSP_RDATA <= p0_sync;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [7:0] busy_len;
  logic [7:0] low_len;
  wire        strobe_low = !RD_N || !WR_N;

  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      busy_len <= 8'h00;
      low_len  <= 8'h00;
    end else begin
      busy_len <= REQ_READY ? 8'h00 : 8'(busy_len + 8'h01);
      low_len  <= strobe_low ? 8'(low_len + 8'h01) : 8'h00;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  a_sel_reset_one: assert property (disable iff (1'b0) RST |=> SEL_CODE == 3'h1) // see (R02)
    else $error("stretch code not one after reset");
  a_access_length: assert property ($rose(REQ_READY) && $past(active)
                                    |-> busy_len == 8'(({5'h00, acc_code} + 8'h02) * 8'h08)) // see (R01)
    else $error("access length wrong for stretch code");
  a_strobe_width: assert property (!strobe_low && $past(strobe_low)
                                   |-> low_len == (acc_code == 3'h0 ? 8'h04
                                       : 8'({5'h00, acc_code} * 8'h08))) // see (R03)
    else $error("strobe width does not match interval");
  a_ale_fast: assert property ($rose(ALE) && acc_code == 3'h0 |-> ALE [*3] ##1 !ALE) // see (R04)
    else $error("latch strobe width wrong unstretched");
  a_ale_slow: assert property ($rose(ALE) && acc_code != 3'h0 |-> ALE [*4] ##1 !ALE) // see (R04)
    else $error("latch strobe width wrong stretched");
  a_strobe_after_ale: assert property ($fell(ALE) |-> if (acc_code == 3'h0) (##1 $rose(strobe_low)) // see (R06)
                                       else (##2 $rose(strobe_low)))
    else $error("strobe gap after latch fall wrong");
  a_read_release: assert property ($fell(RD_N) |-> $past(P0_OE_N) && !$past(P0_OE_N, 2)) // see (R09)
    else $error("port not released before read strobe");
  a_write_hold: assert property ($rose(WR_N) && acc_code != 3'h0 |-> !P0_OE_N [*4] ##1 P0_OE_N) // see (R14)
    else $error("write data hold wrong stretched");
  a_write_addr: assert property ($fell(WR_N) |-> !$past(P0_OE_N, 2) && $past(P0_OUT) == acc_addr[7:0]) // see (R05)
    else $error("low address not held before write strobe");
  a_high_addr: assert property (strobe_low && !$past(strobe_low) |-> P2_OUT == acc_addr[15:8]) // see (R08)
    else $error("high address not valid at strobe");

  c_read_fast: cover property ($rose(RSP_VALID) && acc_code == 3'h0);
  c_write_slow: cover property ($rose(WR_N) && acc_code == 3'h3);
  c_longest: cover property ($rose(REQ_READY) && acc_code == 3'h7);
endmodule // xbus_stretch

/* bench/xram_model.sv */
// Behavioural byte-wide external memory on the multiplexed bus
`timescale 1ns/10ps
module xram_model (
  input  wire logic       clk,
  input  wire logic       slow,
  input  wire logic       ale,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] hi,
  input  wire logic [7:0] pin,
  output logic      [7:0] drv
);
  logic [7:0]  mem [0:65535];
  logic [15:0] addr;
  logic        prev_ale;
  logic        prev_rd;
  logic        prev_wr;
  int          cnt;

  initial begin
    prev_ale = 1'b0;
    prev_rd  = 1'b1;
    prev_wr  = 1'b1;
    cnt      = 0;
    addr     = 16'h0000;
    drv      = 8'h00;
  end

  always @(posedge clk) begin
    prev_ale <= ale;
    prev_rd  <= rd_n;
    prev_wr  <= wr_n;
    cnt      <= rd_n ? 0 : cnt + 1;
    // Transparent latch: the last edge with the strobe high holds the address
    if (ale)
      addr <= {hi, pin};
    if (!prev_wr && wr_n)
      mem[addr] <= pin;
    // Late mode answers one tick before the read strobe rises at the fastest setting
    if (!rd_n && cnt >= (slow ? 2 : 0))
      drv <= mem[addr];
    else if (!(rd_n && !prev_rd))
      drv <= ~drv;
    // Data held through the first tick after the strobe rises
  end
endmodule // xram_model

/* bench/xbus_stretch_tb.sv */
// Self-checking bench for the stretchable external data bus engine
`timescale 1ns/10ps
module xbus_stretch_tb;
  localparam int TK = xbus_pkg::TICKS_PER_OSC;
  logic        SYS_CLK, RST, SEL_LOAD, REQ_VALID, REQ_WRITE, slow;
  logic        REQ_READY, RSP_VALID, ALE, RD_N, WR_N, P0_OE_N;
  logic [2:0]  SEL_DATA, SEL_CODE;
  logic [15:0] REQ_ADDR;
  logic [7:0]  REQ_WDATA, RSP_RDATA, P2_OUT, P0_OUT, drv, rsp, p_p0, p_p2;
  logic        p_ale, p_stb, p_oe_n;
  wire  [7:0]  p0_pin = (P0_OE_N === 1'b0) ? P0_OUT : drv;
  wire         stb = !(RD_N && WR_N);
  int          cyc, t_ar, t_af, t_on, t_off, t_oe, t_oz, t_dat, t_p2;
  int          mismatches, check_count;

  xbus_stretch dut (.SYS_CLK(SYS_CLK), .RST(RST), .SEL_LOAD(SEL_LOAD), .SEL_DATA(SEL_DATA),
    .SEL_CODE(SEL_CODE), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_ADDR(REQ_ADDR),
    .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .RSP_VALID(RSP_VALID), .RSP_RDATA(RSP_RDATA),
    .ALE(ALE), .RD_N(RD_N), .WR_N(WR_N), .P2_OUT(P2_OUT), .P0_OUT(P0_OUT), .P0_OE_N(P0_OE_N),
    .P0_IN(p0_pin));
  xram_model ram (.clk(SYS_CLK), .slow(slow), .ale(ALE), .rd_n(RD_N), .wr_n(WR_N), .hi(P2_OUT),
    .pin(p0_pin), .drv(drv));

  // ----------------------------------------------------------------
  // Edge monitor, times in clock ticks
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK) begin
    cyc    <= cyc + 1;
    p_ale  <= ALE;
    p_stb  <= stb;
    p_oe_n <= P0_OE_N;
    p_p0   <= P0_OUT;
    p_p2   <= P2_OUT;
    if (!p_ale && ALE) t_ar <= cyc;
    if (p_ale && !ALE) t_af <= cyc;
    if (!p_stb && stb) t_on <= cyc;
    if (p_stb && !stb) t_off <= cyc;
    if (p_oe_n && !P0_OE_N) t_oe <= cyc;
    if (!p_oe_n && P0_OE_N) t_oz <= cyc;
    // Only changes while the port stays driven count as data
    if (!p_oe_n && !P0_OE_N && p_p0 != P0_OUT) t_dat <= cyc;
    if (p_p2 != P2_OUT) t_p2 <= cyc;
    if (RSP_VALID) rsp <= RSP_RDATA;
  end

  // ----------------------------------------------------------------
  // Compare and closing tasks
  // ----------------------------------------------------------------
  task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_int(input string n, input int e, input int g);
    check_count++;
    if (g != e) begin
      mismatches++;
      $display("[ERR] %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // One access with full timing judgement
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [15:0] a, input logic [7:0] d, input int c);
    int t0;
    int k;
    @(posedge SYS_CLK); #1;
    REQ_VALID = 1'b1;
    REQ_WRITE = wr;
    REQ_ADDR  = a;
    REQ_WDATA = d;
    rsp       = 8'hxx;
    k = 0;
    @(negedge SYS_CLK);
    while (REQ_READY !== 1'b1 && k < 50) begin @(negedge SYS_CLK); k++; end
    @(posedge SYS_CLK); #1;
    t0 = cyc;
    REQ_VALID = 1'b0;
    @(negedge SYS_CLK);
    while (REQ_READY !== 1'b1 && k < 300) begin @(negedge SYS_CLK); k++; end
    chk_int("length", (c + 2) * 4 * TK, cyc - t0);
    chk_int("strobe width", c ? 4 * c * TK : 2 * TK, t_off - t_on);
    chk_int("ale width", c ? 2 * TK : 3 * TK / 2, t_af - t_ar);
    chk_int("ale to strobe", c ? TK : TK / 2, t_on - t_af);
    chk_int("p0 lead", c ? 2 * TK : TK, t_on - t_oe);
    chk_val("latched addr", a, ram.addr);
    if (wr) begin
      chk_int("p2 lead", c ? 5 * TK / 2 : 3 * TK / 2, t_on - t_p2);
      chk_int("addr hold", c ? TK : TK / 2, t_dat - t_af);
      chk_int("data hold", c ? 2 * TK : TK, t_oz - t_off);
      chk_val("written", {8'h00, d}, {8'h00, ram.mem[a]});
    end else begin
      chk_int("release lead", TK / 2, t_on - t_oz);
      chk_val("read data", {8'h00, d}, {8'h00, rsp});
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    @(posedge SYS_CLK); #1;
    RST = 1'b1;
    repeat (3) @(posedge SYS_CLK);
    #1;
    chk_val("sel_code", 16'h0001, {13'h0, SEL_CODE});
    chk_val("idle pins", 16'h000e, {11'h0, ALE, RD_N, WR_N, P0_OE_N, REQ_READY});
    RST = 1'b0;
    repeat (2) @(posedge SYS_CLK);
    #1;
    chk_val("ready", 16'h0001, {15'h0, REQ_READY});
    xfer(1'b1, 16'h2211, 8'h3c, 1);
    xfer(1'b0, 16'h2211, 8'h3c, 1);
  endtask

  task automatic t_codes;
    for (int c = 0; c < 8; c++) begin
      @(posedge SYS_CLK); #1;
      SEL_LOAD = 1'b1;
      SEL_DATA = c[2:0];
      @(posedge SYS_CLK); #1;
      SEL_LOAD = 1'b0;
      slow     = ~c[0];
      chk_val("sel_code", {13'h0, c[2:0]}, {13'h0, SEL_CODE});
      xfer(1'b1, {8'h30 + 8'(c), 8'h5a}, 8'ha0 + 8'(c), c);
      xfer(1'b0, {8'h30 + 8'(c), 8'h5a}, 8'ha0 + 8'(c), c);
    end
  endtask

  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end

  initial begin
    repeat (6000) @(posedge SYS_CLK);
    mismatches++;
    conclude;
  end

  initial begin
    {RST, SEL_LOAD, REQ_VALID, REQ_WRITE, slow} = 5'b10000;
    {SEL_DATA, REQ_ADDR, REQ_WDATA} = 27'h0;
    {p_ale, p_stb, p_oe_n, p_p0, p_p2} = 19'h1_00_00;
    {cyc, t_ar, t_af, t_on, t_off, t_oe, t_oz, t_dat, t_p2} = '0;
    mismatches  = 0;
    check_count = 0;
    rsp         = 8'h00;
    t_reset;
    t_codes;
    // Second reset in mid-run must bring the default length back
    t_reset;
    conclude;
  end
endmodule // xbus_stretch_tb
